// ==== hw/smacr_ctrl.sv ====
// stop-mode autonomous clock request and power-mode controller
// Behaviour
// (R01) shallow stop keeps all autonomous peripherals and dma alive, and the radio only with voltage range 1
// (R02) in shallow stop the dma runs and reaches both srams
// (R03) radio autonomous only in shallow stop with voltage range 1
// (R04) deep stop keeps non-radio peripherals; they may request shallow stop
// (R05) kernel clock on while any request, off when none
// (R06) fast rc on while any bus clock request, off when none
// (R07) bus request enters shallow stop, clocks enabled peripherals
// (R08) granted bus clock lets dma reach enabled sram and peripheral registers
// (R09) no bus request and deep selected returns to deep stop
// (R10) hardware triggers start autonomous peripherals
// (R11) autonomous peripheral interrupt wakes from either stop mode
// (R12) dma linked list keeps running in shallow stop
// (R13) hardware triggers start memory-to-memory dma transfers
// (R14) hardware triggers gate peripheral-memory dma transfers
// (R15) converter analog watchdog wakes the device from stop
// (R16) bus clock granted in stop comes from fast rc
// (R17) each clock enable is the or of pending requests
module smacr_ctrl (
	input  wire logic                          clock_i,
	input  wire logic                          rst_b_i,
	input  wire logic                          stop_req_i,
	input  wire logic                          deep_sel_i,
	input  wire logic                          range1_i,
	input  wire logic [smacr_pkg::N_PERIPH-1:0] periph_en_i,
	input  wire logic                          first_sram_en_i,
	input  wire logic                          second_sram_en_i,
	input  wire logic                          dma_bus_req_i,
	input  wire logic [smacr_pkg::N_PERIPH-1:0] kclk_req_i,
	input  wire logic [smacr_pkg::N_PERIPH-1:0] bclk_req_i,
	input  wire logic [smacr_pkg::N_PERIPH-1:0] wake_irq_i,
	input  wire logic [smacr_pkg::N_PERIPH-1:0] start_trig_i,
	input  wire logic                          awd_wake_i,
	input  wire logic                          dma_trig_i,
	output logic                               run_o,
	output logic                               shallow_stop_o,
	output logic                               deep_stop_o,
	output logic                               auto_shallow_o,
	output logic      [smacr_pkg::N_PERIPH-1:0] kclk_en_o,
	output logic                               firc_en_o,
	output logic                               bus_src_firc_o,
	output logic                               bus_clk_en_o,
	output logic      [smacr_pkg::N_PERIPH-1:0] periph_bclk_en_o,
	output logic                               dma_clk_en_o,
	output logic                               first_sram_clk_en_o,
	output logic                               second_sram_clk_en_o,
	output logic                               radio_auto_o,
	output logic      [smacr_pkg::N_PERIPH-1:0] periph_start_o,
	output logic                               dma_m2m_start_o,
	output logic                               dma_gate_o,
	output logic                               cpu_wake_o
);

	localparam int unsigned N = smacr_pkg::N_PERIPH;

	// ****************************************************************
	// autonomy decode
	// ****************************************************************
	function automatic logic [N-1:0] auto_mask(
		input smacr_pkg::smacr_mode_e m,
		input logic                   r1
	);
		logic [N-1:0] res;
		res = smacr_pkg::ALL_MASK;
		unique case (m)
			smacr_pkg::ST_RUN:     res = smacr_pkg::ALL_MASK;
			smacr_pkg::ST_DEEP:    res = smacr_pkg::BASE_AUTO_MASK; // R04
			smacr_pkg::ST_SHALLOW,
			smacr_pkg::ST_AUTO:
				res = smacr_pkg::BASE_AUTO_MASK |
					(r1 ? smacr_pkg::RADIO_MASK : smacr_pkg::VEC_RST); // R01
			default:               res = smacr_pkg::BASE_AUTO_MASK;
		endcase
		return res;
	endfunction : auto_mask

	// ****************************************************************
	// input synchronisation
	// ****************************************************************
	logic [smacr_pkg::SYNC_W-1:0] async_vec;
	logic [smacr_pkg::SYNC_W-1:0] sync_vec;
	logic [N-1:0]                 kreq_s;
	logic [N-1:0]                 breq_s;
	logic [N-1:0]                 wake_s;
	logic [N-1:0]                 trig_s;
	logic                         awd_s;
	logic                         dtrig_s;

	assign async_vec = {dma_trig_i, awd_wake_i, start_trig_i,
		wake_irq_i, bclk_req_i, kclk_req_i};

	smacr_sync #(
		.WIDTH (smacr_pkg::SYNC_W)
	) u_sync (
		.clock_i (clock_i),
		.rst_b_i (rst_b_i),
		.async_i (async_vec),
		.sync_o  (sync_vec)
	);

	assign kreq_s  = sync_vec[smacr_pkg::POS_KREQ +: N];
	assign breq_s  = sync_vec[smacr_pkg::POS_BREQ +: N];
	assign wake_s  = sync_vec[smacr_pkg::POS_WAKE +: N];
	assign trig_s  = sync_vec[smacr_pkg::POS_TRIG +: N];
	assign awd_s   = sync_vec[smacr_pkg::POS_AWD];
	assign dtrig_s = sync_vec[smacr_pkg::POS_DTRIG];

	// ****************************************************************
	// mode state machine
	// ****************************************************************
	smacr_pkg::smacr_mode_e state_q;
	smacr_pkg::smacr_mode_e state_d;
	logic [N-1:0]           mask_now;
	logic                   wake_any;
	logic                   bus_req_any;

	always_comb
	begin
		mask_now    = auto_mask(state_q, range1_i);
		wake_any    = (|(wake_s & mask_now)) |
			(awd_s & mask_now[smacr_pkg::IDX_ADC]); // R11 R15
		bus_req_any = (|(breq_s & mask_now)) |
			(dma_bus_req_i & (state_q != smacr_pkg::ST_DEEP)); // R12
		state_d     = state_q;
		unique case (state_q)
			smacr_pkg::ST_RUN:
				if (stop_req_i)
					state_d = deep_sel_i ? smacr_pkg::ST_DEEP
						: smacr_pkg::ST_SHALLOW;
			smacr_pkg::ST_SHALLOW:
				if (wake_any)
					state_d = smacr_pkg::ST_RUN; // R11
			smacr_pkg::ST_DEEP:
				if (wake_any)
					state_d = smacr_pkg::ST_RUN; // R11
				else if (bus_req_any)
					state_d = smacr_pkg::ST_AUTO; // R07
			smacr_pkg::ST_AUTO:
				if (wake_any)
					state_d = smacr_pkg::ST_RUN;
				else if (!bus_req_any)
					state_d = deep_sel_i ? smacr_pkg::ST_DEEP
						: smacr_pkg::ST_SHALLOW; // R09
			default:
				state_d = smacr_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			state_q <= smacr_pkg::ST_RUN;
		else
			state_q <= state_d;
	end

	// ****************************************************************
	// clock enables, starts and wake, computed for the next mode
	// ****************************************************************
	logic [N-1:0] mask_d;
	logic         in_stop_d;
	logic         shallow_d;
	logic         bus_on_d;
	logic [N-1:0] trig_prev_q;
	logic         dtrig_prev_q;
	logic [N-1:0] kclk_en_q;
	logic [N-1:0] kclk_en_d;
	logic         bus_on_q;
	logic [N-1:0] pbclk_q;
	logic [N-1:0] pbclk_d;
	logic         dma_clk_q;
	logic         dma_clk_d;
	logic         first_sram_q;
	logic         first_sram_d;
	logic         second_sram_q;
	logic         second_sram_d;
	logic         radio_q;
	logic         radio_d;
	logic [N-1:0] start_q;
	logic [N-1:0] start_d;
	logic         m2m_q;
	logic         m2m_d;
	logic         gate_q;
	logic         gate_d;
	logic         wake_q;
	logic         wake_d;

	always_comb
	begin
		mask_d    = auto_mask(state_d, range1_i);
		in_stop_d = (state_d != smacr_pkg::ST_RUN);
		shallow_d = (state_d == smacr_pkg::ST_SHALLOW) |
			(state_d == smacr_pkg::ST_AUTO);
		bus_on_d  = shallow_d & ((|(breq_s & mask_d)) | dma_bus_req_i); // R06
		kclk_en_d = in_stop_d ? (kreq_s & mask_d) : periph_en_i; // R05 R17
		pbclk_d   = (!in_stop_d | bus_on_d) ? periph_en_i
			: smacr_pkg::VEC_RST; // R07
		dma_clk_d = !in_stop_d | bus_on_d; // R02 R08
		first_sram_d   = dma_clk_d & first_sram_en_i; // R02
		second_sram_d   = dma_clk_d & second_sram_en_i; // R02
		radio_d   = shallow_d & range1_i; // R03
		start_d   = trig_s & ~trig_prev_q & mask_d; // R10
		m2m_d     = dtrig_s & ~dtrig_prev_q & dma_clk_d; // R13
		gate_d    = dtrig_s & dma_clk_d; // R14
		wake_d    = (state_q != smacr_pkg::ST_RUN) &
			(state_d == smacr_pkg::ST_RUN); // R11
	end

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			trig_prev_q  <= smacr_pkg::VEC_RST;
			dtrig_prev_q <= smacr_pkg::BIT_RST;
			kclk_en_q    <= smacr_pkg::VEC_RST;
			bus_on_q     <= smacr_pkg::BIT_RST;
			pbclk_q      <= smacr_pkg::VEC_RST;
			dma_clk_q    <= smacr_pkg::BIT_RST;
			first_sram_q      <= smacr_pkg::BIT_RST;
			second_sram_q      <= smacr_pkg::BIT_RST;
			radio_q      <= smacr_pkg::BIT_RST;
			start_q      <= smacr_pkg::VEC_RST;
			m2m_q        <= smacr_pkg::BIT_RST;
			gate_q       <= smacr_pkg::BIT_RST;
			wake_q       <= smacr_pkg::BIT_RST;
		end
		else
		begin
			trig_prev_q  <= trig_s;
			dtrig_prev_q <= dtrig_s;
			kclk_en_q    <= kclk_en_d;
			bus_on_q     <= bus_on_d;
			pbclk_q      <= pbclk_d;
			dma_clk_q    <= dma_clk_d;
			first_sram_q      <= first_sram_d;
			second_sram_q      <= second_sram_d;
			radio_q      <= radio_d;
			start_q      <= start_d;
			m2m_q        <= m2m_d;
			gate_q       <= gate_d;
			wake_q       <= wake_d;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign run_o            = (state_q == smacr_pkg::ST_RUN);
	assign shallow_stop_o   = (state_q == smacr_pkg::ST_SHALLOW);
	assign deep_stop_o      = (state_q == smacr_pkg::ST_DEEP);
	assign auto_shallow_o   = (state_q == smacr_pkg::ST_AUTO);
	assign kclk_en_o        = kclk_en_q;
	assign firc_en_o        = bus_on_q;
	assign bus_src_firc_o   = !run_o; // R16
	assign bus_clk_en_o     = bus_on_q;
	assign periph_bclk_en_o = pbclk_q;
	assign dma_clk_en_o     = dma_clk_q;
	assign first_sram_clk_en_o   = first_sram_q;
	assign second_sram_clk_en_o   = second_sram_q;
	assign radio_auto_o     = radio_q;
	assign periph_start_o   = start_q;
	assign dma_m2m_start_o  = m2m_q;
	assign dma_gate_o       = gate_q;
	assign cpu_wake_o       = wake_q;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);

	auto_entry_a : assert property ( // R07
		(deep_stop_o && !wake_any && bus_req_any)
		|=> auto_shallow_o && bus_clk_en_o && firc_en_o
	) else $error("bus request did not leave deep stop");

	auto_return_a : assert property ( // R09
		(auto_shallow_o && !wake_any && !bus_req_any && deep_sel_i)
		|=> deep_stop_o && !bus_clk_en_o ##1 deep_stop_o || cpu_wake_o
			|| auto_shallow_o
	) else $error("idle shallow stop did not return to deep stop");

	kclk_or_a : assert property ( // R05
		!run_o |-> kclk_en_o ==
			($past(kreq_s) & auto_mask(state_q, $past(range1_i)))
	) else $error("kernel clock enable not the masked request or");

	firc_off_a : assert property ( // R06
		(deep_stop_o || (shallow_stop_o && $past(!bus_req_any)))
		|-> !firc_en_o
	) else $error("fast rc running without request");

	radio_mode_a : assert property ( // R03
		radio_auto_o |-> (shallow_stop_o || auto_shallow_o) && $past(range1_i)
	) else $error("radio autonomous outside shallow stop range 1");

	deep_radio_a : assert property ( // R04
		deep_stop_o |-> !kclk_en_o[smacr_pkg::IDX_RADIO]
	) else $error("radio kernel clock in deep stop");

	stop_wake_a : assert property ( // R11
		(!run_o && wake_any) |=> run_o && cpu_wake_o ##1 !cpu_wake_o
	) else $error("interrupt did not wake the device");

	awd_wake_a : assert property ( // R15
		(!run_o && awd_s) |=> cpu_wake_o
	) else $error("analog watchdog did not wake the device");

	trig_start_a : assert property ( // R10
		(|(trig_s & ~trig_prev_q & auto_mask(state_d, range1_i)))
		|=> (|periph_start_o)
	) else $error("trigger edge did not start a peripheral");

	dma_access_a : assert property ( // R08
		(first_sram_clk_en_o || second_sram_clk_en_o || (|periph_bclk_en_o))
		|-> dma_clk_en_o && (run_o || bus_clk_en_o)
	) else $error("dma access without granted bus clock");

	dma_chain_a : assert property ( // R12
		(auto_shallow_o && dma_bus_req_i && !wake_any) |=> auto_shallow_o
	) else $error("dma linked list lost its bus clock");

	m2m_start_a : assert property ( // R13
		$rose(dtrig_s) && dma_clk_d |=> dma_m2m_start_o ##1 !dma_m2m_start_o
	) else $error("dma trigger did not start transfer");

	dma_gate_a : assert property ( // R14
		dma_gate_o |-> dma_clk_en_o && $past(dtrig_s)
	) else $error("dma gate without trigger or clock");

endmodule : smacr_ctrl

// ==== hw/smacr_pkg.sv ====
// constants shared by the stop-mode autonomous clock request controller
package smacr_pkg;

	// ****************************************************************
	// peripheral slots
	// ****************************************************************
	localparam int unsigned N_PERIPH   = 11;
	localparam int unsigned IDX_ADC    = 0;
	localparam int unsigned IDX_LPTIM1 = 1;
	localparam int unsigned IDX_LPTIM2 = 2;
	localparam int unsigned IDX_SER1   = 3;
	localparam int unsigned IDX_SER2   = 4;
	localparam int unsigned IDX_LPSER  = 5;
	localparam int unsigned IDX_SPI1   = 6;
	localparam int unsigned IDX_SPI2   = 7;
	localparam int unsigned IDX_I2C1   = 8;
	localparam int unsigned IDX_I2C2   = 9;
	localparam int unsigned IDX_RADIO  = 10;

	// ****************************************************************
	// autonomy masks and reset values
	// ****************************************************************
	localparam logic [N_PERIPH-1:0] BASE_AUTO_MASK = 11'h3FF;
	localparam logic [N_PERIPH-1:0] RADIO_MASK     = 11'h400;
	localparam logic [N_PERIPH-1:0] ALL_MASK       = 11'h7FF;
	localparam logic [N_PERIPH-1:0] VEC_RST        = 11'h000;
	localparam logic                BIT_RST        = 1'h0;

	// ****************************************************************
	// synchroniser layout: kernel, bus, wake, trigger, awd, dma trigger
	// ****************************************************************
	localparam int unsigned SYNC_W    = 4 * N_PERIPH + 2;
	localparam int unsigned POS_KREQ  = 0;
	localparam int unsigned POS_BREQ  = N_PERIPH;
	localparam int unsigned POS_WAKE  = 2 * N_PERIPH;
	localparam int unsigned POS_TRIG  = 3 * N_PERIPH;
	localparam int unsigned POS_AWD   = 4 * N_PERIPH;
	localparam int unsigned POS_DTRIG = 4 * N_PERIPH + 1;

	// ****************************************************************
	// power modes
	// ****************************************************************
	typedef enum logic [3:0]
	{
		ST_RUN     = 4'h1,
		ST_SHALLOW = 4'h2,
		ST_DEEP    = 4'h4,
		ST_AUTO    = 4'h8
	} smacr_mode_e;

endpackage : smacr_pkg

// ==== hw/smacr_sync.sv ====
// two-flop synchroniser for a vector of independent asynchronous levels
module smacr_sync #(
	parameter int unsigned WIDTH = smacr_pkg::SYNC_W
) (
	input  wire logic             clock_i,
	input  wire logic             rst_b_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	// ****************************************************************
	// two stages
	// ****************************************************************
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb
	begin
		meta_d = async_i;
		sync_d = meta_q;
	end

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;

endmodule : smacr_sync

// ==== verification/smacr_periph_model.sv ====
// far-side model: autonomous peripherals and dma raising request levels
module smacr_periph_model (
	input  wire logic                         clock_i,
	input  wire logic                         slow_i,
	input  wire logic [smacr_pkg::SYNC_W-1:0] want_i,
	output logic      [smacr_pkg::SYNC_W-1:0] req_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [smacr_pkg::SYNC_W-1:0] hold_q;

	initial
	begin
		req_o  = '0;
		hold_q = '0;
	end

	// ****************************************************************
	// request lines
	// ****************************************************************
	// levels move off the controller's edge, as unrelated sources do;
	// slow mode answers one cycle late
	always @(posedge clock_i)
	begin
		#7;
		req_o  <= slow_i ? hold_q : want_i;
		hold_q <= want_i;
	end

endmodule : smacr_periph_model

// ==== verification/smacr_ctrl_tb.sv ====
// self-checking bench for the stop-mode clock request controller
module smacr_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int N = smacr_pkg::N_PERIPH;
	localparam int W = smacr_pkg::SYNC_W;

	logic         clock_i, rst_b_i, stop_req, deep_sel, range1, slow;
	logic         s1_en, s2_en, dma_req, run, shal, deep, auto_s, firc;
	logic         src, bus_en, dma_clk, s1_clk, s2_clk, radio, m2m, gate;
	logic         wake;
	logic [N-1:0] pen, kclk, pbclk, pstart;
	logic [W-1:0] want, req;
	int           fails, cmp_count, n_start, n_m2m, n_wake, idx;

	smacr_periph_model i_model (.clock_i(clock_i), .slow_i(slow),
		.want_i(want), .req_o(req));

	smacr_ctrl i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.stop_req_i(stop_req), .deep_sel_i(deep_sel), .range1_i(range1),
		.periph_en_i(pen), .first_sram_en_i(s1_en), .second_sram_en_i(s2_en),
		.dma_bus_req_i(dma_req),
		.kclk_req_i(req[smacr_pkg::POS_KREQ +: N]),
		.bclk_req_i(req[smacr_pkg::POS_BREQ +: N]),
		.wake_irq_i(req[smacr_pkg::POS_WAKE +: N]),
		.start_trig_i(req[smacr_pkg::POS_TRIG +: N]),
		.awd_wake_i(req[smacr_pkg::POS_AWD]),
		.dma_trig_i(req[smacr_pkg::POS_DTRIG]),
		.run_o(run), .shallow_stop_o(shal), .deep_stop_o(deep),
		.auto_shallow_o(auto_s), .kclk_en_o(kclk), .firc_en_o(firc),
		.bus_src_firc_o(src), .bus_clk_en_o(bus_en),
		.periph_bclk_en_o(pbclk), .dma_clk_en_o(dma_clk),
		.first_sram_clk_en_o(s1_clk), .second_sram_clk_en_o(s2_clk),
		.radio_auto_o(radio), .periph_start_o(pstart),
		.dma_m2m_start_o(m2m), .dma_gate_o(gate), .cpu_wake_o(wake));

	initial
	begin
		clock_i = 1'h0;
		forever #12.5 clock_i = ~clock_i;
	end

	// pulse counters, sampled before the edge's own updates land
	always @(posedge clock_i)
	begin
		n_start <= n_start + $countones(pstart);
		n_m2m   <= n_m2m + int'(m2m);
		n_wake  <= n_wake + int'(wake);
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	task automatic chk(input logic [N-1:0] got, input logic [N-1:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#2;
	endtask : tick

	task automatic wait_mode(input logic [3:0] m);
		for (int i = 0; i < 20; i++)
		begin
			if ({auto_s, deep, shal, run} === m)
				return;
			tick(1);
		end
		fails++;
		$display("Error at %0t: mode %h expected %h", $time,
			{auto_s, deep, shal, run}, m);
		test_done();
	endtask : wait_mode

	task automatic enter_stop(input logic dsel);
		deep_sel = dsel;
		stop_req = 1'h1;
		tick(1);
		stop_req = 1'h0;
		wait_mode(dsel ? 4'h4 : 4'h2);
	endtask : enter_stop

	function automatic logic [N-1:0] exp_kclk(input logic in_run,
		input logic sh, input logic r1, input logic [N-1:0] kreq);
		if (in_run)
			return pen;
		return kreq & (smacr_pkg::BASE_AUTO_MASK |
			((sh && r1) ? smacr_pkg::RADIO_MASK : smacr_pkg::VEC_RST));
	endfunction : exp_kclk

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		{rst_b_i, stop_req, deep_sel, range1, slow, dma_req} = 6'h00;
		{s1_en, s2_en} = 2'h0;
		pen = '0;
		want = '0;
		{fails, cmp_count, n_start, n_m2m, n_wake} = '0;
		void'($urandom(32'h6F72));
		repeat (12) @(posedge clock_i);
		#2;
		rst_b_i = 1'h1;
		tick(1);
		for (int i = 0; i < 4; i++)
		begin
			pen = N'($urandom);
			{s1_en, s2_en} = 2'($urandom);
			tick(2);
			chk(kclk, exp_kclk(1'h1, 1'h0, 1'h0, '0));
			chk(s1_clk, s1_en);
			chk(s2_clk, s2_en);
			chk(src, 1'h0);
		end
		$display("test run enables done");
		enter_stop(1'h1);
		chk(src, 1'h1);
		chk(pbclk, '0);
		for (int i = 0; i < 4; i++)
		begin
			range1 = 1'($urandom);
			slow = 1'($urandom);
			want[smacr_pkg::POS_KREQ +: N] = N'($urandom);
			tick(6);
			chk(kclk, exp_kclk(1'h0, 1'h0, range1,
				want[smacr_pkg::POS_KREQ +: N]));
		end
		want = '0;
		tick(6);
		chk(kclk, '0);
		$display("test kernel requests done");
		range1 = 1'h1;
		want[smacr_pkg::POS_BREQ + N - 1] = 1'h1;
		tick(6);
		chk(deep, 1'h1);
		want = '0;
		for (int i = 0; i < 3; i++)
		begin
			idx = $urandom % (N - 1);
			slow = 1'($urandom);
			want[smacr_pkg::POS_BREQ + idx] = 1'h1;
			wait_mode(4'h8);
			tick(1);
			chk(firc, 1'h1);
			chk(bus_en, 1'h1);
			chk(pbclk, pen);
			chk({s1_clk, s2_clk}, {s1_en, s2_en});
			chk(radio, 1'h1);
			n_m2m = 0;
			n_start = 0;
			want[smacr_pkg::POS_DTRIG] = 1'h1;
			want[smacr_pkg::POS_TRIG + idx] = 1'h1;
			tick(8);
			chk(gate, 1'h1);
			chk(n_m2m, 1);
			chk(n_start, 1);
			// dma linked list alone must hold the auto shallow stop
			dma_req = 1'h1;
			want = '0;
			tick(6);
			chk({auto_s, firc}, 2'h3);
			dma_req = 1'h0;
			wait_mode(4'h4);
			tick(1);
			chk({firc, bus_en, dma_clk}, 3'h0);
		end
		$display("test bus requests done");
		n_wake = 0;
		want[smacr_pkg::POS_WAKE + $urandom % (N - 1)] = 1'h1;
		wait_mode(4'h1);
		tick(2);
		chk(n_wake, 1);
		chk(kclk, pen);
		want = '0;
		// let the synchronised wake level drain before stopping again
		tick(6);
		$display("test wake done");
		enter_stop(1'h0);
		dma_req = 1'h1;
		tick(2);
		chk({dma_clk, firc}, 2'h3);
		n_start = 0;
		want[smacr_pkg::POS_TRIG + N - 1] = 1'h1;
		tick(8);
		chk(n_start, 1);
		dma_req = 1'h0;
		want = '0;
		tick(2);
		chk({shal, firc}, 2'h2);
		n_wake = 0;
		want[smacr_pkg::POS_AWD] = 1'h1;
		wait_mode(4'h1);
		tick(2);
		chk(n_wake, 1);
		want = '0;
		$display("test shallow dma and watchdog done");
		test_done();
	end

endmodule : smacr_ctrl_tb
